// ### design/pic_pkg.sv
// Purpose: Shared constants and carriers of the priority interrupt controller
// Assumes: 16-bit registers in the low half of 32-bit Avalon words
// Notes:   Byte offsets, field positions and reset values live here only
package pic_pkg;

	localparam int               REG_W         = 16;
	localparam int               BUS_W         = 32;
	localparam int               ADDR_W        = 8;
	localparam int               PRIO_W        = 3;
	localparam int               LEVEL_W       = 4;
	localparam int               VEC_W         = 8;
	localparam int               CPL_W         = 3;
	localparam int               PRIO_PER_WORD = 4;
	localparam int               PRIO_STRIDE   = 4;
	localparam int               WORD_BYTES    = 4;
	localparam logic [VEC_W-1:0] VEC_BASE      = 8'h08;

	////////////////////////////////////////////////////////////////////////////
	// Byte offsets
	localparam logic [ADDR_W-1:0] OFS_GC1        = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_GC2        = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_GC3        = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_GC4        = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_VLS        = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CPU_STAT   = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CORE_CTRL  = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_FLAGS      = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_ENABLES    = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_PRIO       = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h60;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 8'h64;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h68;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int NEST_BIT      = 15;
	localparam int TRAP1_LSB     = 1;
	localparam int TRAP1_W       = 4;
	localparam int GLOBAL_EN_BIT = 15;
	localparam int EXT_EDGE_BIT  = 0;
	localparam int DMA_BIT       = 0;
	localparam int LOOP_BIT      = 1;
	localparam int TRAP3_W       = 2;
	localparam int SOFT_TRAP_BIT = 0;
	localparam int VEC_LSB       = 0;
	localparam int LEVEL_LSB     = 8;
	localparam int CPL_LSB       = 5;
	localparam int TOP_BIT       = 3;
	localparam int EV_PEND       = 0;
	localparam int EV_TRAP       = 1;
	localparam int EV_W          = 2;

	localparam logic [CPL_W-1:0] NEST_LEVEL = 3'h7;
	localparam logic             WAIT_RESET = 1'h1;

	////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic               valid;
		logic [VEC_W-1:0]   vector;
		logic [LEVEL_W-1:0] level;
	} pic_pick_t;

	typedef struct packed {
		logic osc_fail;
		logic stack_err;
		logic addr_err;
		logic math_err;
		logic dma_err;
		logic loop_ovf;
		logic soft_hard;
	} pic_trap_t;

endpackage : pic_pkg

// ### design/pic_ext_sync.sv
// Purpose: Synchronise an external request pin and detect its active edge
// Assumes: Pin is asynchronous to clock
// Notes:   Pulse lags the pin by three clock edges
`timescale 1ns/1ps
`default_nettype none
module pic_ext_sync (
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic pin,
	input  wire logic falling,
	output var  logic pulse
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic pulse;
	} pic_sync_state_t;

	pic_sync_state_t s;
	pic_sync_state_t next_s;

	always_comb
	begin
		next_s       = s;
		next_s.s1    = pin;
		next_s.s2    = s.s1;
		next_s.s3    = s.s2;
		// First stage feeds only the second
		next_s.pulse = falling ? (s.s3 & ~s.s2) : (s.s2 & ~s.s3);
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign pulse = s.pulse;

endmodule : pic_ext_sync
`default_nettype wire

// ### design/pic_prio_pick.sv
// Purpose: Choose the highest-priority eligible source
// Assumes: Pure combinational; caller registers the result
// Notes:   Ties go to the lowest source index, the natural order
`timescale 1ns/1ps
`default_nettype none
module pic_prio_pick #(
	parameter int NUM_SRC = 16
) (
	input  wire logic [NUM_SRC-1:0]                flags,
	input  wire logic [NUM_SRC-1:0]                enables,
	input  wire logic [NUM_SRC*pic_pkg::PRIO_W-1:0] prios,
	input  wire logic                              global_en,
	input  wire logic [pic_pkg::LEVEL_W-1:0]       cur_level,
	output var  pic_pkg::pic_pick_t                pick
);

	always_comb
	begin
		logic [pic_pkg::LEVEL_W-1:0] p;
		p    = '0;
		pick = '0;
		// Descending scan with >= lets the lower index win a tie
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			p = pic_pkg::LEVEL_W'(prios[i*pic_pkg::PRIO_W +: pic_pkg::PRIO_W]);
			if (global_en && flags[i] && enables[i] && (p > cur_level) &&
				(!pick.valid || p >= pick.level)) // [RL13]
			begin
				pick.valid  = 1'h1;
				pick.vector = pic_pkg::VEC_BASE + pic_pkg::VEC_W'(i); // [RL6]
				pick.level  = p; // [RL5]
			end
		end
	end

endmodule : pic_prio_pick
`default_nettype wire

// ### design/pic_top.sv
// Purpose: Prioritised interrupt controller with Avalon-MM register slave
// Assumes: Single clock; peripheral and trap events are one-cycle pulses
// Notes:   Source 0 is the external request pin, the rest are peripheral pulses
//
// How it works
// [RL1] Each source has a sticky request flag set by hardware, cleared by software.
// [RL2] Each source has its own enable bit gating its request.
// [RL3] Each source has a three-bit priority field, eight levels.
// [RL4] Pending vector number and new level are latched into the status register.
// [RL5] The latched new level equals the pending source's priority.
// [RL6] Fields are in vector order; source zero is vector eight, bit zero.
// [RL7] Current level low three bits sit at bits 7:5, software writable.
// [RL8] Fourth level bit in core control is read-only, driven by traps.
// [RL9] First global register holds nesting disable and processor trap flags.
// [RL10] Second global register holds external edge select and global enable.
// [RL11] Third global register holds DMA and loop-stack overflow trap flags.
// [RL12] Fourth global register holds the software hard trap flag.
// [RL13] Source presented only if flagged, enabled, globally enabled, above current level.
`timescale 1ns/1ps
`default_nettype none
module pic_top #(
	parameter int NUM_SRC = 16
) (
	input  wire logic                        clock,
	input  wire logic                        reset_n,
	input  wire logic [pic_pkg::ADDR_W-1:0]  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [pic_pkg::BUS_W-1:0]   avs_writedata,
	output var  logic [pic_pkg::BUS_W-1:0]   avs_readdata,
	output var  logic                        avs_waitrequest,
	input  wire logic                        external_request_zero,
	input  wire logic [NUM_SRC-1:1]          periph_event,
	input  wire pic_pkg::pic_trap_t          trap_event,
	input  wire logic                        cpu_ack,
	output var  logic                        cpu_irq_req,
	output var  logic [pic_pkg::VEC_W-1:0]   cpu_vector,
	output var  logic [pic_pkg::LEVEL_W-1:0] cpu_level,
	output var  logic [pic_pkg::LEVEL_W-1:0] cpu_priority,
	output var  logic                        irq
);

	localparam int PRIO_WORDS = NUM_SRC / pic_pkg::PRIO_PER_WORD;
	localparam int PRIO_BITS  = NUM_SRC * pic_pkg::PRIO_W;

	typedef struct packed {
		logic                         waitreq;
		logic [pic_pkg::BUS_W-1:0]    rdata;
		logic                         nesting_disable;
		logic [pic_pkg::TRAP1_W-1:0]  trap1;
		logic                         global_irq_enable;
		logic                         ext_zero_falling;
		logic [pic_pkg::TRAP3_W-1:0]  trap3;
		logic                         soft_hard_trap_flag;
		logic [pic_pkg::VEC_W-1:0]    vector_number;
		logic [pic_pkg::LEVEL_W-1:0]  new_priority_level;
		logic [pic_pkg::CPL_W-1:0]    cpu_priority_level;
		logic                         cpu_priority_top_bit;
		logic [NUM_SRC-1:0]           request_flag_regs;
		logic [NUM_SRC-1:0]           source_enable_regs;
		logic [PRIO_BITS-1:0]         source_priority_regs;
		logic                         pend;
		logic [pic_pkg::EV_W-1:0]     irq_status;
		logic [pic_pkg::EV_W-1:0]     irq_enable;
		logic                         irq;
	} pic_state_t;

	pic_state_t                      s;
	pic_state_t                      next_s;
	pic_pkg::pic_pick_t              pick;
	logic                            ext_pulse;
	logic [pic_pkg::LEVEL_W-1:0]     cur_level;
	logic                            any_trap;
	logic                            wr_ok;
	logic [pic_pkg::TRAP1_W-1:0]     trap1_ev;
	logic [pic_pkg::TRAP3_W-1:0]     trap3_ev;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [pic_pkg::ADDR_W-1:0] prio_addr(input int k);
		return pic_pkg::ADDR_W'(int'(pic_pkg::OFS_PRIO) + k * pic_pkg::WORD_BYTES);
	endfunction : prio_addr

	// Write of zero clears; a hardware set in the same cycle wins
	function automatic logic [pic_pkg::REG_W-1:0] flag_upd(
		input logic [pic_pkg::REG_W-1:0] cur,
		input logic                      we,
		input logic [pic_pkg::REG_W-1:0] wd,
		input logic [pic_pkg::REG_W-1:0] ev
	);
		return (we ? (cur & wd) : cur) | ev;
	endfunction : flag_upd

	function automatic logic [pic_pkg::BUS_W-1:0] read_word(
		input logic [pic_pkg::ADDR_W-1:0] a
	);
		logic [pic_pkg::REG_W-1:0] w;
		w = '0;
		case (a)
			pic_pkg::OFS_GC1:
			begin
				w[pic_pkg::NEST_BIT]                        = s.nesting_disable;
				w[pic_pkg::TRAP1_LSB +: pic_pkg::TRAP1_W]   = s.trap1;
			end
			pic_pkg::OFS_GC2:
			begin
				w[pic_pkg::GLOBAL_EN_BIT] = s.global_irq_enable;
				w[pic_pkg::EXT_EDGE_BIT]  = s.ext_zero_falling;
			end
			pic_pkg::OFS_GC3:        w[pic_pkg::TRAP3_W-1:0] = s.trap3;
			pic_pkg::OFS_GC4:        w[pic_pkg::SOFT_TRAP_BIT] = s.soft_hard_trap_flag;
			pic_pkg::OFS_VLS:
			begin
				w[pic_pkg::VEC_LSB +: pic_pkg::VEC_W]       = s.vector_number;
				w[pic_pkg::LEVEL_LSB +: pic_pkg::LEVEL_W]   = s.new_priority_level;
			end
			pic_pkg::OFS_CPU_STAT:   w[pic_pkg::CPL_LSB +: pic_pkg::CPL_W] = s.cpu_priority_level;
			pic_pkg::OFS_CORE_CTRL:  w[pic_pkg::TOP_BIT] = s.cpu_priority_top_bit;
			pic_pkg::OFS_FLAGS:      w = pic_pkg::REG_W'(s.request_flag_regs);
			pic_pkg::OFS_ENABLES:    w = pic_pkg::REG_W'(s.source_enable_regs);
			pic_pkg::OFS_IRQ_STATUS: w = pic_pkg::REG_W'(s.irq_status);
			pic_pkg::OFS_IRQ_ENABLE: w = pic_pkg::REG_W'(s.irq_enable);
			default:
			begin
				for (int k = 0; k < PRIO_WORDS; k++)
					if (a == prio_addr(k))
						for (int j = 0; j < pic_pkg::PRIO_PER_WORD; j++)
							w[j*pic_pkg::PRIO_STRIDE +: pic_pkg::PRIO_W] =
								s.source_priority_regs[(k*pic_pkg::PRIO_PER_WORD+j)*
								pic_pkg::PRIO_W +: pic_pkg::PRIO_W];
			end
		endcase
		return pic_pkg::BUS_W'(w);
	endfunction : read_word

	////////////////////////////////////////////////////////////////////////////
	// Submodules

	pic_ext_sync u_ext_sync (
		.clock   (clock),
		.reset_n (reset_n),
		.pin     (external_request_zero),
		.falling (s.ext_zero_falling),
		.pulse   (ext_pulse)
	);

	pic_prio_pick #(
		.NUM_SRC (NUM_SRC)
	) u_pick (
		.flags     (s.request_flag_regs),
		.enables   (s.source_enable_regs),
		.prios     (s.source_priority_regs),
		.global_en (s.global_irq_enable),
		.cur_level (cur_level),
		.pick      (pick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state

	assign cur_level = {s.cpu_priority_top_bit, s.cpu_priority_level};
	assign any_trap  = (|s.trap1) | (|s.trap3) | s.soft_hard_trap_flag;
	assign wr_ok     = avs_write && !s.waitreq;
	assign trap1_ev  = {trap_event.math_err, trap_event.addr_err,
		trap_event.stack_err, trap_event.osc_fail};
	assign trap3_ev  = {trap_event.loop_ovf, trap_event.dma_err};

	always_comb
	begin
		logic [pic_pkg::REG_W-1:0] wd;
		logic [pic_pkg::EV_W-1:0]  ev;
		wd     = avs_writedata[pic_pkg::REG_W-1:0];
		ev     = '0;
		next_s = s;

		// One wait cycle, then the answer; idle waitrequest stays high
		if (s.waitreq && (avs_read || avs_write))
		begin
			next_s.waitreq = 1'h0;
			next_s.rdata   = read_word(avs_address);
		end
		else
			next_s.waitreq = pic_pkg::WAIT_RESET;

		if (wr_ok && avs_address == pic_pkg::OFS_GC1)
			next_s.nesting_disable = wd[pic_pkg::NEST_BIT]; // [RL9]
		next_s.trap1 = pic_pkg::TRAP1_W'(flag_upd(pic_pkg::REG_W'(s.trap1),
			wr_ok && avs_address == pic_pkg::OFS_GC1,
			pic_pkg::REG_W'(wd[pic_pkg::TRAP1_LSB +: pic_pkg::TRAP1_W]),
			pic_pkg::REG_W'(trap1_ev))); // [RL9]

		if (wr_ok && avs_address == pic_pkg::OFS_GC2)
		begin
			next_s.global_irq_enable = wd[pic_pkg::GLOBAL_EN_BIT]; // [RL10]
			next_s.ext_zero_falling  = wd[pic_pkg::EXT_EDGE_BIT]; // [RL10]
		end

		next_s.trap3 = pic_pkg::TRAP3_W'(flag_upd(pic_pkg::REG_W'(s.trap3),
			wr_ok && avs_address == pic_pkg::OFS_GC3,
			pic_pkg::REG_W'(wd[pic_pkg::TRAP3_W-1:0]), pic_pkg::REG_W'(trap3_ev))); // [RL11]

		next_s.soft_hard_trap_flag = (wr_ok && avs_address == pic_pkg::OFS_GC4) ?
			(s.soft_hard_trap_flag & wd[pic_pkg::SOFT_TRAP_BIT]) | trap_event.soft_hard :
			s.soft_hard_trap_flag | trap_event.soft_hard; // [RL12]

		next_s.request_flag_regs = NUM_SRC'(flag_upd(pic_pkg::REG_W'(s.request_flag_regs),
			wr_ok && avs_address == pic_pkg::OFS_FLAGS, wd,
			pic_pkg::REG_W'({periph_event, ext_pulse}))); // [RL1] [RL6]

		if (wr_ok && avs_address == pic_pkg::OFS_ENABLES)
			next_s.source_enable_regs = wd[NUM_SRC-1:0]; // [RL2]

		for (int k = 0; k < PRIO_WORDS; k++)
			if (wr_ok && avs_address == prio_addr(k))
				for (int j = 0; j < pic_pkg::PRIO_PER_WORD; j++)
					next_s.source_priority_regs[(k*pic_pkg::PRIO_PER_WORD+j)*
						pic_pkg::PRIO_W +: pic_pkg::PRIO_W] =
						wd[j*pic_pkg::PRIO_STRIDE +: pic_pkg::PRIO_W]; // [RL3]

		// Latch the presented source; last values hold when nothing is pending
		next_s.pend = pick.valid; // [RL13]
		if (pick.valid)
		begin
			next_s.vector_number      = pick.vector; // [RL4]
			next_s.new_priority_level = pick.level; // [RL4] [RL5]
		end

		if (wr_ok && avs_address == pic_pkg::OFS_CPU_STAT)
			next_s.cpu_priority_level = wd[pic_pkg::CPL_LSB +: pic_pkg::CPL_W]; // [RL7]
		// Acceptance by the core outranks a software write in the same cycle
		if (cpu_ack && s.pend)
			next_s.cpu_priority_level = s.nesting_disable ? pic_pkg::NEST_LEVEL :
				s.new_priority_level[pic_pkg::CPL_W-1:0];

		// Software cannot touch the top bit, so traps stay unmaskable
		next_s.cpu_priority_top_bit = any_trap; // [RL8]

		ev[pic_pkg::EV_PEND] = pick.valid && !s.pend;
		ev[pic_pkg::EV_TRAP] = (|trap1_ev) | (|trap3_ev) | trap_event.soft_hard;
		next_s.irq_status = (wr_ok && avs_address == pic_pkg::OFS_IRQ_CLEAR) ?
			(s.irq_status & ~wd[pic_pkg::EV_W-1:0]) | ev : s.irq_status | ev;
		if (wr_ok && avs_address == pic_pkg::OFS_IRQ_ENABLE)
			next_s.irq_enable = wd[pic_pkg::EV_W-1:0];
		next_s.irq = |(next_s.irq_status & next_s.irq_enable);
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s         <= '0;
			s.waitreq <= pic_pkg::WAIT_RESET;
		end
		else
			s <= next_s;
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign avs_readdata    = s.rdata;
	assign avs_waitrequest = s.waitreq;
	assign cpu_irq_req     = s.pend;
	assign cpu_vector      = s.vector_number;
	assign cpu_level       = s.new_priority_level;
	assign cpu_priority    = cur_level;
	assign irq             = s.irq;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	AST_FLAG_SET: assert property (periph_event[1] |=> s.request_flag_regs[1]) // [RL1]
		else $error("peripheral event did not set its flag");
	AST_FLAG_HOLD: assert property (!(wr_ok && avs_address == pic_pkg::OFS_FLAGS) |=>
		((s.request_flag_regs & $past(s.request_flag_regs)) == $past(s.request_flag_regs))) // [RL1]
		else $error("flag dropped without a software write");
	AST_ENABLE_GATE: assert property ((s.source_enable_regs == '0) |=> !cpu_irq_req) // [RL2]
		else $error("request presented with all sources disabled");
	AST_LEVEL_RANGE: assert property (cpu_irq_req |-> !cpu_level[pic_pkg::TOP_BIT] &&
		cpu_level != '0) // [RL3]
		else $error("presented level outside one to seven");
	AST_LATCH: assert property (pick.valid |=> s.vector_number == $past(pick.vector) &&
		s.new_priority_level == $past(pick.level)) // [RL4]
		else $error("vector and level not latched");
	AST_VEC_RANGE: assert property (cpu_irq_req |-> cpu_vector >= pic_pkg::VEC_BASE &&
		cpu_vector < pic_pkg::VEC_BASE + pic_pkg::VEC_W'(NUM_SRC)) // [RL6]
		else $error("vector outside the source range");
	AST_LEVEL_WRITE: assert property (wr_ok && avs_address == pic_pkg::OFS_CPU_STAT &&
		!(cpu_ack && s.pend) |=> s.cpu_priority_level ==
		$past(avs_writedata[pic_pkg::CPL_LSB +: pic_pkg::CPL_W])) // [RL7]
		else $error("current level write lost");
	AST_TOP_BIT: assert property (##1 s.cpu_priority_top_bit == $past(any_trap)) // [RL8]
		else $error("top priority bit not tracking traps");
	AST_TRAP_ONE: assert property (trap_event.math_err |=> s.trap1[pic_pkg::TRAP1_W-1] &&
		cpu_priority[pic_pkg::TOP_BIT] == 1'h0 ##1 cpu_priority[pic_pkg::TOP_BIT]) // [RL9]
		else $error("math trap not recorded");
	AST_NO_GLOBAL: assert property (!s.global_irq_enable |=> !cpu_irq_req) // [RL10]
		else $error("request presented while globally disabled");
	AST_TRAP_THREE: assert property (trap_event.dma_err |=> s.trap3[pic_pkg::DMA_BIT]) // [RL11]
		else $error("DMA trap not recorded");
	AST_SOFT_TRAP: assert property (trap_event.soft_hard |=> s.soft_hard_trap_flag) // [RL12]
		else $error("software hard trap not recorded");
	AST_ABOVE_LEVEL: assert property (cpu_irq_req |-> cpu_level > $past(cur_level)) // [RL13]
		else $error("presented level not above current level");
	AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=>
		!avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle");

	COV_PRESENT: cover property (!cpu_irq_req ##1 cpu_irq_req);
	COV_ACK_NEST: cover property (cpu_ack && s.pend && s.nesting_disable);
	COV_TRAP_TOP: cover property (trap_event.osc_fail ##2 cpu_priority[pic_pkg::TOP_BIT]);
	COV_READ: cover property (avs_read && !avs_waitrequest);

endmodule : pic_top
`default_nettype wire

// ### tb/pic_cpu_model.sv
// Purpose: Processor core side: accepts presented interrupts
// Assumes: One clock shared with the controller
// Notes:   Acks once per presentation, after ack_delay cycles
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       ack_enable,
	input  wire logic [3:0] ack_delay,
	input  wire logic       cpu_irq_req,
	input  wire logic [7:0] cpu_vector,
	output var  logic       cpu_ack,
	output var  logic [7:0] taken_vector
);
	logic [3:0] wait_cnt;
	logic       served;

	////////////////////////////////////////////////////////////////////////////
	// Waits for the request to drop before the next ack, so one event is not taken twice
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wait_cnt <= 4'h0;
			served <= 1'b0;
			cpu_ack <= 1'b0;
			taken_vector <= 8'h00;
		end
		else
		begin
			cpu_ack <= 1'b0;
			if (!cpu_irq_req || !ack_enable)
			begin
				wait_cnt <= 4'h0;
				served <= 1'b0;
			end
			else if (!served && wait_cnt == ack_delay)
			begin
				cpu_ack <= 1'b1;
				taken_vector <= cpu_vector;
				served <= 1'b1;
			end
			else if (!served)
				wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule : pic_cpu_model
`default_nettype wire

// ### tb/pic_tb_top.sv
// Purpose: Self-checking bench of the priority interrupt controller
// Assumes: Avalon master with one wait cycle per access
// Notes:   Traps are left set briefly; scenarios build on state that earlier ones leave set
`timescale 1ns/1ps
`default_nettype none
module pic_tb_top;
	logic                 clock = 1'b0;
	logic                 reset_n = 1'b0;
	logic [7:0]           avs_address = 8'h00;
	logic                 avs_read = 1'b0;
	logic                 avs_write = 1'b0;
	logic [31:0]          avs_writedata = 32'h0;
	logic [31:0]          avs_readdata;
	logic                 avs_waitrequest;
	logic                 ext_pin = 1'b0;
	logic [15:1]          periph_event = 15'h0;
	pic_pkg::pic_trap_t   trap_event = '0;
	logic                 cpu_ack, cpu_irq_req, irq, ack_enable = 1'b0;
	logic [3:0]           ack_delay = 4'h0;
	logic [7:0]           cpu_vector, taken_vector;
	logic [3:0]           cpu_level, cpu_priority;
	int                   num_errors = 0;
	int                   cmp_count = 0;

	always #10 clock = ~clock;

	pic_top #(.NUM_SRC(16)) dut_u (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.external_request_zero(ext_pin), .periph_event(periph_event), .trap_event(trap_event),
		.cpu_ack(cpu_ack), .cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector),
		.cpu_level(cpu_level), .cpu_priority(cpu_priority), .irq(irq));

	pic_cpu_model cpu_u (.clock(clock), .reset_n(reset_n), .ack_enable(ack_enable),
		.ack_delay(ack_delay), .cpu_irq_req(cpu_irq_req), .cpu_vector(cpu_vector),
		.cpu_ack(cpu_ack), .taken_vector(taken_vector));

	////////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick

	// Request held until waitrequest is sampled low; bounded so a hang is seen
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clock);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= {16'h0000, d};
		do
		begin
			@(posedge clock);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		r = avs_readdata;
		if (n >= 50)
			num_errors++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		logic [31:0] r;
		bus(1'b0, a, 16'h0000, r);
		chk(r, {16'h0000, e});
	endtask : rdc

	task automatic pulse(input int i);
		logic [15:0] v;
		v = 16'h0001 << i;
		@(posedge clock);
		periph_event <= v[15:1];
		@(posedge clock);
		periph_event <= 15'h0;
	endtask : pulse

	task automatic trap(input int i);
		@(posedge clock);
		trap_event <= pic_pkg::pic_trap_t'(7'h01 << i);
		@(posedge clock);
		trap_event <= '0;
	endtask : trap

	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rdc(pic_pkg::OFS_GC2, 16'h0000);
		rdc(pic_pkg::OFS_VLS, 16'h0000);
		rdc(pic_pkg::OFS_PRIO, 16'h0000);
		rdc(pic_pkg::OFS_ENABLES, 16'h0000);
		wr(8'h30, 16'hffff);
		rdc(8'h30, 16'h0000);
	endtask : t_reset

	task automatic t_present;
		wr(pic_pkg::OFS_ENABLES, 16'h0002);
		wr(pic_pkg::OFS_PRIO, 16'h0050);
		pulse(1);
		tick(3);
		chk(cpu_irq_req, 1'b0);
		rdc(pic_pkg::OFS_FLAGS, 16'h0002);
		wr(pic_pkg::OFS_GC2, 16'h8000);
		tick(3);
		chk({cpu_irq_req, cpu_vector, cpu_level}, {1'b1, 8'h09, 4'h5});
		rdc(pic_pkg::OFS_VLS, 16'h0509);
		wr(pic_pkg::OFS_ENABLES, 16'h0000);
		tick(3);
		chk(cpu_irq_req, 1'b0);
		wr(pic_pkg::OFS_ENABLES, 16'h0002);
	endtask : t_present

	task automatic t_levels;
		for (int p = 0; p < 8; p++)
		begin
			wr(pic_pkg::OFS_PRIO, 16'(p << 4));
			tick(3);
			// Level zero is never presented; the last latched level stays
			chk({cpu_irq_req, cpu_level}, p == 0 ? 5'h05 : {1'b1, 4'(p)});
		end
		wr(pic_pkg::OFS_CPU_STAT, 16'h0060);
		rdc(pic_pkg::OFS_CPU_STAT, 16'h0060);
		wr(pic_pkg::OFS_PRIO, 16'h0030);
		tick(3);
		chk(cpu_irq_req, 1'b0);
		wr(pic_pkg::OFS_PRIO, 16'h0040);
		tick(3);
		chk(cpu_irq_req, 1'b1);
		wr(pic_pkg::OFS_FLAGS, 16'hfffd);
		rdc(pic_pkg::OFS_FLAGS, 16'h0000);
		wr(pic_pkg::OFS_CPU_STAT, 16'h0000);
	endtask : t_levels

	task automatic t_ack;
		ack_enable <= 1'b1;
		wr(pic_pkg::OFS_PRIO, 16'h0050);
		pulse(1);
		tick(12);
		chk({cpu_priority, taken_vector, 3'h0, cpu_irq_req}, {4'h5, 8'h09, 4'h0});
		wr(pic_pkg::OFS_FLAGS, 16'h0000);
		wr(pic_pkg::OFS_CPU_STAT, 16'h0000);
		wr(pic_pkg::OFS_GC1, 16'h8000);
		ack_delay <= 4'h6;
		pulse(2);
		pulse(1);
		tick(20);
		chk(cpu_priority, 4'h7);
		ack_enable <= 1'b0;
		wr(pic_pkg::OFS_FLAGS, 16'h0000);
		wr(pic_pkg::OFS_GC1, 16'h0000);
		wr(pic_pkg::OFS_CPU_STAT, 16'h0000);
	endtask : t_ack

	task automatic t_traps;
		logic [7:0] ofs;
		logic [15:0] m;
		for (int i = 0; i < 7; i++)
		begin
			ofs = i == 0 ? pic_pkg::OFS_GC4 : (i < 3 ? pic_pkg::OFS_GC3 : pic_pkg::OFS_GC1);
			m = i == 0 ? 16'h0001 : (i == 1 ? 16'h0002 : (i == 2 ? 16'h0001 : 16'(1 << (7 - i))));
			trap(i);
			tick(2);
			rdc(ofs, m);
			chk(cpu_priority[3], 1'b1);
			wr(pic_pkg::OFS_CORE_CTRL, 16'h0000);
			rdc(pic_pkg::OFS_CORE_CTRL, 16'h0008);
			wr(ofs, 16'h0000);
			tick(2);
			chk(cpu_priority, 4'h0);
		end
	endtask : t_traps

	task automatic t_irq;
		wr(pic_pkg::OFS_IRQ_CLEAR, 16'h0003);
		wr(pic_pkg::OFS_IRQ_ENABLE, 16'h0002);
		trap(0);
		tick(2);
		chk(irq, 1'b1);
		rdc(pic_pkg::OFS_IRQ_STATUS, 16'h0002);
		wr(pic_pkg::OFS_IRQ_CLEAR, 16'h0002);
		tick(1);
		chk(irq, 1'b0);
		wr(pic_pkg::OFS_IRQ_ENABLE, 16'h0000);
		trap(1);
		tick(2);
		chk(irq, 1'b0);
		rdc(pic_pkg::OFS_IRQ_STATUS, 16'h0002);
		wr(pic_pkg::OFS_GC3, 16'h0000);
		wr(pic_pkg::OFS_GC4, 16'h0000);
	endtask : t_irq

	task automatic t_ext;
		wr(pic_pkg::OFS_PRIO, 16'h0006);
		wr(pic_pkg::OFS_ENABLES, 16'h0001);
		ext_pin <= 1'b1;
		tick(8);
		chk({cpu_irq_req, cpu_vector, cpu_level}, {1'b1, 8'h08, 4'h6});
		// New pending plus the loop trap left from the irq scenario
		rdc(pic_pkg::OFS_IRQ_STATUS, 16'h0003);
		wr(pic_pkg::OFS_FLAGS, 16'hfffe);
		wr(pic_pkg::OFS_GC2, 16'h8001);
		rdc(pic_pkg::OFS_FLAGS, 16'h0000);
		ext_pin <= 1'b0;
		tick(8);
		rdc(pic_pkg::OFS_FLAGS, 16'h0001);
	endtask : t_ext

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		tick(8);
		reset_n <= 1'b1;
		t_reset();
		t_present();
		t_levels();
		t_ack();
		t_traps();
		t_irq();
		t_ext();
		finish_test();
	end

	// Whole run is under a hundred accesses; far beyond that means a hang
	initial
	begin
		tick(20000);
		num_errors++;
		finish_test();
	end
endmodule : pic_tb_top
`default_nettype wire
